// file: rtl/osrs_pkg.sv
// Shared constants for the operation status register bank: set and
// register selectors, bit positions, used-bit masks and preset values.
// Assumes a 16-bit status word whose top bit always reads zero.
package osrs_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned MSB_BIT = 15;
  typedef logic [WORD_W-1:0] osrs_word_t;

  // Register sets of the bank; code 3'h7 is not a set
  typedef enum logic [2:0] {
    SET_TOP = 3'h0,
    SET_ZC = 3'h1,
    SET_LL = 3'h2,
    SET_ACQ = 3'h3,
    SET_PMR = 3'h4,
    SET_TRG = 3'h5,
    SET_HL = 3'h6
  } osrs_set_e;
  localparam int unsigned NUM_SETS = 7;

  // Registers within one set; codes above 3'h4 are not registers
  typedef enum logic [2:0] {
    REG_COND = 3'h0,
    REG_EVENT = 3'h1,
    REG_ENABLE = 3'h2,
    REG_RISE = 3'h3,
    REG_FALL = 3'h4
  } osrs_reg_e;

  // Summary bit positions in the top operation word
  localparam int unsigned TOP_ZC_BIT = 0;
  localparam int unsigned TOP_ACQ_BIT = 4;
  localparam int unsigned TOP_TRG_BIT = 5;
  localparam int unsigned TOP_PMR_BIT = 10;
  localparam int unsigned TOP_LL_BIT = 11;
  localparam int unsigned TOP_HL_BIT = 12;

  // Child layouts: channel A at bit 1, limit tests from bit 1 upward
  localparam int unsigned CH_A_BIT = 1;
  localparam int unsigned CH_N = 2;
  localparam int unsigned LIM_LO_BIT = 1;
  localparam int unsigned LIM_N = 6;

  // Bits that can ever be nonzero in each set, the writable-bit mask and whole-word constants
  localparam osrs_word_t TOP_MASK = 16'h1C31;
  localparam osrs_word_t CH_MASK = 16'h0006;
  localparam osrs_word_t LIM_MASK = 16'h007E;
  localparam osrs_word_t WR_MASK = 16'h7FFF;
  localparam osrs_word_t WORD_ZERO = 16'h0000;
  localparam osrs_word_t WORD_ONES = 16'hFFFF;

  // Preset and reset values of the filter and enable registers
  localparam osrs_word_t TOP_EN_PRESET = 16'h0000;
  localparam osrs_word_t CHILD_EN_PRESET = 16'hFFFF;
  localparam osrs_word_t RISE_PRESET = 16'hFFFF;
  localparam osrs_word_t FALL_PRESET = 16'h0000;

  localparam osrs_word_t SET_MASK [NUM_SETS] = '{
    TOP_MASK, CH_MASK, LIM_MASK, CH_MASK, CH_MASK, CH_MASK, LIM_MASK};
  localparam osrs_word_t SET_EN_PRESET [NUM_SETS] = '{
    TOP_EN_PRESET, CHILD_EN_PRESET, CHILD_EN_PRESET, CHILD_EN_PRESET,
    CHILD_EN_PRESET, CHILD_EN_PRESET, CHILD_EN_PRESET};

endpackage

// file: rtl/osrs_set.sv
// One status register set: edge filters, sticky event word, enable
// mask and the OR summary that feeds the parent's condition bit.
// Assumes cond is a registered or stable level sampled on sys_clk.
`timescale 1ns/1ps
module osrs_set
  import osrs_pkg::*;
#(
  parameter osrs_word_t USED_MASK = WORD_ONES,
  parameter osrs_word_t EN_PRESET = WORD_ONES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire osrs_word_t cond,
  input wire logic preset,
  input wire logic wr_enable,
  input wire logic wr_rise,
  input wire logic wr_fall,
  input wire osrs_word_t wdata,
  input wire logic ev_clear,
  output osrs_word_t event_val,
  output osrs_word_t enable_val,
  output osrs_word_t rise_val,
  output osrs_word_t fall_val,
  output logic summary
);

  // The top bit can never be set, so a mask that uses it is refused
  if (USED_MASK[MSB_BIT] != 1'b0) begin : g_bad_mask
    $error("osrs_set: top bit of the used mask must be zero");
  end

  typedef struct packed {
    osrs_word_t last;
    osrs_word_t evt;
    osrs_word_t en;
    osrs_word_t rise;
    osrs_word_t fall;
  } osrs_set_s;

  osrs_set_s st;
  osrs_set_s next_st;
  osrs_word_t c;
  osrs_word_t up;
  osrs_word_t down;

  ////////////////////////////////////////////////////////////////////
  // Edge filters and sticky event; a new edge beats a read clear
  always_comb begin
    next_st = st;
    c = cond & USED_MASK;
    up = c & ~st.last & st.rise; // R20
    down = ~c & st.last & st.fall; // R20
    next_st.last = c;
    next_st.evt = ((ev_clear ? WORD_ZERO : st.evt) | up | down) & USED_MASK; // R18
    if (preset) begin
      next_st.en = EN_PRESET & WR_MASK; // R17
      next_st.rise = RISE_PRESET & WR_MASK; // R17
      next_st.fall = FALL_PRESET & WR_MASK; // R17
    end else begin
      if (wr_enable) begin
        next_st.en = wdata & WR_MASK;
      end
      if (wr_rise) begin
        next_st.rise = wdata & WR_MASK;
      end
      if (wr_fall) begin
        next_st.fall = wdata & WR_MASK;
      end
    end
  end

  // Reset leaves the filters as a preset would
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '{WORD_ZERO, WORD_ZERO, EN_PRESET & WR_MASK,
              RISE_PRESET & WR_MASK, FALL_PRESET & WR_MASK}; // R23
    end else begin
      st <= next_st;
    end
  end

  assign event_val = st.evt;
  assign enable_val = st.en;
  assign rise_val = st.rise;
  assign fall_val = st.fall;
  assign summary = |(st.evt & st.en); // R22

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  evt_clear_read_a: assert property (ev_clear && !(|(up | down)) |=> event_val == WORD_ZERO) // R18
    else $error("event word not cleared by read");
  evt_latch_a: assert property (|(up | down) |=> (event_val & $past(up | down)) == $past(up | down)) // R20
    else $error("filtered edge did not latch event");
  evt_hold_a: assert property (!ev_clear && !(|(up | down)) |=> $stable(event_val)) // R20
    else $error("event changed without edge or read");
  preset_load_a: assert property (preset |=> enable_val == (EN_PRESET & WR_MASK) && rise_val == (RISE_PRESET & WR_MASK) && fall_val == WORD_ZERO) // R17
    else $error("preset values not loaded");
  summary_or_a: assert property (summary == |(event_val & enable_val)) // R22
    else $error("summary is not masked OR of events");

endmodule

// file: rtl/osrs_status_bank.sv
// Operation status bank: top summary set and six child sets, driven by
// measurement engine events and reached through the command port.
// Assumes all inputs are synchronous to sys_clk and pulses last one
// cycle; one command per cycle, answered one cycle later.
`timescale 1ns/1ps

// Operation
// R1: Top word: zero/cal bit 0, acq 4, trigger 5, probe 10, low 11, high 12.
// R2: Top word unused bits read zero; bit 15 always zero.
// R3: Zero/cal set: channel A bit 1, channel B bit 2, rest zero.
// R4: Zero/cal busy sets on zeroing, calibration or calibrate-all start.
// R5: Zero/cal busy clears when that operation finishes.
// R6: Low-limit set: channels, windows, window lower measurements at bits 1-6.
// R7: Low-limit bit sets when its channel or window low test fails.
// R8: Limit bits clear only on an enabled test that passes.
// R9: Acquisition set: channel A bit 1, channel B bit 2, rest zero.
// R10: Acquisition bit high while that channel measures, low when done.
// R11: Acquisition bits work only in averaging mode, zero otherwise.
// R12: Probe memory set: channel A bit 1, channel B bit 2.
// R13: Probe memory bit high only while reading sensor calibration memory.
// R14: Trigger wait set: channel A bit 1, channel B bit 2, rest zero.
// R15: High-limit set: same six bit layout as the low-limit set.
// R16: High-limit bit sets when its channel or window high test fails.
// R17: Preset: top enable zeros, others ones; rise ones; fall zeros.
// R18: Reading an event word returns it and clears it.
// R19: Reading a condition word leaves it unchanged.
// R20: Event bits latch on filtered rising or falling condition edges.
// R21: Each parent summary bit is the OR of its child's output.
// R22: Child output is OR of event masked by enable.
// R23: Reset clears conditions and events, loads preset filters and enables.
module osrs_status_bank
  import osrs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic cmd_preset,
  input wire logic [2:0] cmd_set,
  input wire logic [2:0] cmd_reg,
  input wire osrs_word_t cmd_wdata,
  output osrs_word_t rsp_data,
  output logic rsp_valid,
  output logic rsp_error,
  input wire logic [CH_N-1:0] zero_start,
  input wire logic [CH_N-1:0] cal_start,
  input wire logic [CH_N-1:0] cal_all_start,
  input wire logic [CH_N-1:0] zero_cal_done,
  input wire logic [LIM_N-1:0] low_limit_fail,
  input wire logic [LIM_N-1:0] low_limit_pass,
  input wire logic [LIM_N-1:0] high_limit_fail,
  input wire logic [LIM_N-1:0] high_limit_pass,
  input wire logic avg_mode,
  input wire logic [CH_N-1:0] acq_busy,
  input wire logic [CH_N-1:0] probe_mem_busy,
  input wire logic [CH_N-1:0] trig_wait,
  output logic op_summary
);

  typedef struct packed {
    logic [CH_N-1:0] zc;
    logic [LIM_N-1:0] ll;
    logic [LIM_N-1:0] hl;
    osrs_word_t rdata;
    logic rvalid;
    logic rerror;
  } osrs_bank_s;

  osrs_bank_s st;
  osrs_bank_s next_st;

  osrs_word_t cond_w [NUM_SETS];
  osrs_word_t ev_w [NUM_SETS];
  osrs_word_t en_w [NUM_SETS];
  osrs_word_t ri_w [NUM_SETS];
  osrs_word_t fa_w [NUM_SETS];
  logic [NUM_SETS-1:0] sum_w;
  logic [NUM_SETS-1:0] wr_en_hit;
  logic [NUM_SETS-1:0] wr_ri_hit;
  logic [NUM_SETS-1:0] wr_fa_hit;
  logic [NUM_SETS-1:0] ev_rd_hit;
  logic set_ok;
  logic reg_ok;
  logic wr_ok;
  logic [CH_N-1:0] zc_begin;

  ////////////////////////////////////////////////////////////////////
  // Command decode; set 3'h7 and register codes above fall are unmapped
  assign set_ok = cmd_set <= SET_HL;
  assign reg_ok = cmd_reg <= REG_FALL;
  // Condition and event words are read only; a preset in the same cycle drops any write
  assign wr_ok = cmd_write && set_ok && !cmd_preset &&
                 (cmd_reg == REG_ENABLE || cmd_reg == REG_RISE ||
                  cmd_reg == REG_FALL);

  always_comb begin
    for (int i = 0; i < NUM_SETS; i++) begin
      wr_en_hit[i] = wr_ok && cmd_set == 3'(i) && cmd_reg == REG_ENABLE;
      wr_ri_hit[i] = wr_ok && cmd_set == 3'(i) && cmd_reg == REG_RISE;
      wr_fa_hit[i] = wr_ok && cmd_set == 3'(i) && cmd_reg == REG_FALL;
      ev_rd_hit[i] = cmd_read && cmd_set == 3'(i) && cmd_reg == REG_EVENT; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Condition words of the child sets and of the top word
  assign zc_begin = zero_start | cal_start | cal_all_start; // R4

  always_comb begin
    cond_w[SET_ZC] = osrs_word_t'(st.zc) << CH_A_BIT; // R3
    cond_w[SET_LL] = osrs_word_t'(st.ll) << LIM_LO_BIT; // R6
    // Outside averaging mode nobody reports acquisition activity
    cond_w[SET_ACQ] = avg_mode ? (osrs_word_t'(acq_busy) << CH_A_BIT)
                               : WORD_ZERO; // R9 R10 R11
    // Probe memory reads are reported straight from the engine level
    cond_w[SET_PMR] = osrs_word_t'(probe_mem_busy) << CH_A_BIT; // R12 R13
    cond_w[SET_TRG] = osrs_word_t'(trig_wait) << CH_A_BIT; // R14
    cond_w[SET_HL] = osrs_word_t'(st.hl) << LIM_LO_BIT; // R15
    // Top word is built from child outputs; all other bits stay zero
    cond_w[SET_TOP] = WORD_ZERO; // R2
    cond_w[SET_TOP][TOP_ZC_BIT] = sum_w[SET_ZC]; // R1 R21
    cond_w[SET_TOP][TOP_ACQ_BIT] = sum_w[SET_ACQ]; // R1 R21
    cond_w[SET_TOP][TOP_TRG_BIT] = sum_w[SET_TRG]; // R1 R21
    cond_w[SET_TOP][TOP_PMR_BIT] = sum_w[SET_PMR]; // R1 R21
    cond_w[SET_TOP][TOP_LL_BIT] = sum_w[SET_LL]; // R1 R21
    cond_w[SET_TOP][TOP_HL_BIT] = sum_w[SET_HL]; // R1 R21
  end

  ////////////////////////////////////////////////////////////////////
  // The seven register sets share one structure
  for (genvar g = 0; g < NUM_SETS; g++) begin : g_set
    osrs_set #(
      .USED_MASK(SET_MASK[g]),
      .EN_PRESET(SET_EN_PRESET[g])
    ) u_set (
      .sys_clk(sys_clk),
      .rst(rst),
      .cond(cond_w[g]),
      .preset(cmd_preset),
      .wr_enable(wr_en_hit[g]),
      .wr_rise(wr_ri_hit[g]),
      .wr_fall(wr_fa_hit[g]),
      .wdata(cmd_wdata),
      .ev_clear(ev_rd_hit[g]),
      .event_val(ev_w[g]),
      .enable_val(en_w[g]),
      .rise_val(ri_w[g]),
      .fall_val(fa_w[g]),
      .summary(sum_w[g])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // Held conditions and the read answer
  always_comb begin
    next_st = st;
    // A start in the same cycle as a finish keeps the channel busy
    next_st.zc = (st.zc & ~zero_cal_done) | zc_begin; // R4 R5
    // A fail beats a pass arriving together; only a pass clears
    next_st.ll = (st.ll & ~low_limit_pass) | low_limit_fail; // R7 R8
    next_st.hl = (st.hl & ~high_limit_pass) | high_limit_fail; // R16 R8
    next_st.rvalid = cmd_read;
    next_st.rerror = (cmd_read && !(set_ok && reg_ok)) ||
                     (cmd_write && !wr_ok && !cmd_preset);
    next_st.rdata = WORD_ZERO;
    if (cmd_read && set_ok) begin
      unique case (osrs_reg_e'(cmd_reg))
        REG_COND: next_st.rdata = cond_w[cmd_set]; // R19
        REG_EVENT: next_st.rdata = ev_w[cmd_set]; // R18
        REG_ENABLE: next_st.rdata = en_w[cmd_set];
        REG_RISE: next_st.rdata = ri_w[cmd_set];
        REG_FALL: next_st.rdata = fa_w[cmd_set];
        default: next_st.rdata = WORD_ZERO;
      endcase
    end
  end

  // Conditions start clear; sets reset themselves
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0; // R23
    end else begin
      st <= next_st;
    end
  end

  assign rsp_data = st.rdata;
  assign rsp_valid = st.rvalid;
  assign rsp_error = st.rerror;
  // Feeds the status byte above this bank
  assign op_summary = sum_w[SET_TOP]; // R21

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  zc_start_a: assert property (zero_start[0] || cal_all_start[0] |=> cond_w[SET_ZC][CH_A_BIT]) // R4
    else $error("busy not set on zero or cal start");
  zc_done_a: assert property (zero_cal_done[1] && !zc_begin[1] |=> !cond_w[SET_ZC][CH_A_BIT+1]) // R5
    else $error("busy not cleared at finish");
  ll_fail_a: assert property (low_limit_fail[3] |=> cond_w[SET_LL][LIM_LO_BIT+3]) // R7
    else $error("low limit fail not set");
  hl_fail_a: assert property (high_limit_fail[5] |=> cond_w[SET_HL][LIM_LO_BIT+5]) // R16
    else $error("high limit fail not set");
  lim_keep_a: assert property (!low_limit_pass[0] && !low_limit_fail[0] |=> $stable(st.ll[0])) // R8
    else $error("limit bit changed without a test");
  lim_pass_a: assert property (high_limit_pass[2] && !high_limit_fail[2] |=> !st.hl[2]) // R8
    else $error("passing test did not clear limit bit");
  acq_mode_a: assert property (!avg_mode |-> cond_w[SET_ACQ] == WORD_ZERO) // R11
    else $error("acquisition bits outside averaging mode");
  top_unused_a: assert property ((cond_w[SET_TOP] & ~TOP_MASK) == WORD_ZERO) // R2
    else $error("unused top bit set");
  top_map_a: assert property (cond_w[SET_TOP][TOP_LL_BIT] == |(ev_w[SET_LL] & en_w[SET_LL])) // R21
    else $error("low limit summary mismatch");
  ev_read_a: assert property (cmd_read && cmd_set == SET_HL && cmd_reg == REG_EVENT |=> rsp_valid && rsp_data == $past(ev_w[SET_HL])) // R18
    else $error("event read returned wrong word");
  cond_read_a: assert property (cmd_read && cmd_set == SET_ZC && cmd_reg == REG_COND |=> rsp_data == $past(cond_w[SET_ZC])) // R19
    else $error("condition read returned wrong word");

  preset_c: cover property (cmd_preset ##1 cmd_read);
  zc_cycle_c: cover property (zero_start[0] ##[1:20] zero_cal_done[0]);
  top_sum_c: cover property (op_summary);
  ev_read_c: cover property (cmd_read && cmd_reg == REG_EVENT && ev_w[SET_LL] != WORD_ZERO);

endmodule

// file: sim/osrs_tb.sv
// Self-checking bench for the operation status register bank.
// Assumes the command port answers one cycle after each request.
`timescale 1ns/1ps
module testbench
  import osrs_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_read = 1'b0, cmd_write = 1'b0, cmd_preset = 1'b0;
  logic [2:0] cmd_set = 3'h0, cmd_reg = 3'h0;
  osrs_word_t cmd_wdata = 16'h0000, rsp_data;
  logic rsp_valid, rsp_error, avg_mode = 1'b0, op_summary;
  logic [1:0] zero_start = 2'h0, cal_start = 2'h0, cal_all_start = 2'h0, zero_cal_done = 2'h0;
  logic [5:0] low_limit_fail = 6'h00, low_limit_pass = 6'h00;
  logic [5:0] high_limit_fail = 6'h00, high_limit_pass = 6'h00;
  logic [1:0] acq_busy = 2'h0, probe_mem_busy = 2'h0, trig_wait = 2'h0;
  int errors = 0, checks_done = 0;
  logic [31:0] lfsr = 32'hA8FDE0CD;
  osrs_word_t exp_q[$];
  string name_q[$];

  osrs_status_bank i_osrs_status_bank (.sys_clk(sys_clk), .rst(rst), .cmd_read(cmd_read),
    .cmd_write(cmd_write), .cmd_preset(cmd_preset), .cmd_set(cmd_set), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .zero_start(zero_start), .cal_start(cal_start), .cal_all_start(cal_all_start),
    .zero_cal_done(zero_cal_done), .low_limit_fail(low_limit_fail),
    .low_limit_pass(low_limit_pass), .high_limit_fail(high_limit_fail),
    .high_limit_pass(high_limit_pass), .avg_mode(avg_mode), .acq_busy(acq_busy),
    .probe_mem_busy(probe_mem_busy), .trig_wait(trig_wait), .op_summary(op_summary));

  // Free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers: compare, closing report, random source, idle cycles
  task automatic cmp(input string n, input osrs_word_t e, input osrs_word_t g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmpb(input string n, input logic e, input logic g);
    cmp(n, {15'h0000, e}, {15'h0000, g});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Galois shift register, fixed seed so runs repeat
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Command port drivers; reads leave their expectation in the queue
  task automatic rd(input logic [2:0] s, input logic [2:0] r, input osrs_word_t e);
    @(posedge sys_clk);
    cmd_read <= 1'b1;
    cmd_set <= s;
    cmd_reg <= r;
    exp_q.push_back(e);
    name_q.push_back($sformatf("read set %0d reg %0d", s, r));
    @(posedge sys_clk);
    cmd_read <= 1'b0;
    @(negedge sys_clk);
    cmpb("read error flag", (s == 3'h7) || (r > 3'h4), rsp_error);
  endtask

  task automatic wr(input logic [2:0] s, input logic [2:0] r, input osrs_word_t d);
    @(posedge sys_clk);
    cmd_write <= 1'b1;
    cmd_set <= s;
    cmd_reg <= r;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_write <= 1'b0;
    @(negedge sys_clk);
    cmpb("write error flag", (s == 3'h7) || (r > 3'h4) || (r < 3'h2), rsp_error);
  endtask

  // Engine pulses; four idle edges cover child event, top condition and top event
  task automatic pulse_zc(input logic [1:0] z, c, a, d);
    @(posedge sys_clk);
    zero_start <= z;
    cal_start <= c;
    cal_all_start <= a;
    zero_cal_done <= d;
    @(posedge sys_clk);
    {zero_start, cal_start, cal_all_start, zero_cal_done} <= 8'h00;
    tick(4);
  endtask

  task automatic lim(input logic [2:0] s, input logic [5:0] f, input logic [5:0] p);
    @(posedge sys_clk);
    if (s == 3'h2) {low_limit_fail, low_limit_pass} <= {f, p};
    else {high_limit_fail, high_limit_pass} <= {f, p};
    @(posedge sys_clk);
    {low_limit_fail, low_limit_pass, high_limit_fail, high_limit_pass} <= 24'h000000;
    tick(4);
  endtask

  task automatic chk_defaults(input bit full);
    for (int s = 0; s < 7; s++) begin
      rd(s[2:0], 3'h2, (s == 0) ? 16'h0000 : 16'h7FFF);
      rd(s[2:0], 3'h3, 16'h7FFF);
      rd(s[2:0], 3'h4, 16'h0000);
      if (full) begin
        rd(s[2:0], 3'h0, 16'h0000);
        rd(s[2:0], 3'h1, 16'h0000);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: every read answer is matched against the oldest note
  always @(negedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        errors++;
        $display("CHECK FAILED rsp_valid expected 0 seen 1");
      end else begin
        cmp(name_q.pop_front(), exp_q.pop_front(), rsp_data);
      end
    end
  end

  // Hang guard, far beyond the length of the sequence
  initial begin
    tick(20000);
    errors++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    osrs_word_t acc;
    logic [2:0] s;
    logic [1:0] prev;
    tick(3);
    rst <= 1'b0;
    chk_defaults(1'b1);
    $display("test reset values done");
    // Zeroing and calibration busy, summaries and read-clear
    wr(3'h0, 3'h2, 16'h1C31);
    pulse_zc(2'h1, 2'h0, 2'h0, 2'h0);
    @(negedge sys_clk);
    cmpb("op_summary", 1'b1, op_summary);
    rd(3'h1, 3'h0, 16'h0002);
    rd(3'h0, 3'h0, 16'h0001);
    rd(3'h0, 3'h1, 16'h0001);
    tick(2);
    @(negedge sys_clk);
    cmpb("op_summary", 1'b0, op_summary);
    rd(3'h1, 3'h1, 16'h0002);
    rd(3'h1, 3'h1, 16'h0000);
    rd(3'h1, 3'h0, 16'h0002);
    rd(3'h0, 3'h0, 16'h0000);
    pulse_zc(2'h0, 2'h0, 2'h0, 2'h1);
    rd(3'h1, 3'h0, 16'h0000);
    pulse_zc(2'h0, 2'h2, 2'h0, 2'h0);
    rd(3'h1, 3'h0, 16'h0004);
    pulse_zc(2'h0, 2'h0, 2'h1, 2'h0);
    rd(3'h1, 3'h0, 16'h0006);
    pulse_zc(2'h0, 2'h0, 2'h0, 2'h3);
    rd(3'h1, 3'h0, 16'h0000);
    $display("test zero cal done");
    // Limit sets: every test bit, partial pass, fail beating pass
    for (int k = 0; k < 2; k++) begin
      s = (k == 0) ? 3'h2 : 3'h6;
      acc = 16'h0000;
      for (int i = 0; i < 6; i++) begin
        lim(s, 6'h01 << i, 6'h00);
        acc = acc | (16'h0002 << i);
        rd(s, 3'h0, acc);
      end
      // Top word before the read-clear; the zero/cal event is still pending
      rd(3'h0, 3'h0, (k == 0) ? 16'h0801 : 16'h1801);
      rd(s, 3'h1, 16'h007E);
      lim(s, 6'h00, 6'h15);
      rd(s, 3'h0, 16'h0054);
      lim(s, 6'h01, 6'h3F);
      rd(s, 3'h0, 16'h0002);
      lim(s, 6'h00, 6'h3F);
      rd(s, 3'h0, 16'h0000);
    end
    $display("test limits done");
    // Acquisition only counts in averaging mode
    @(posedge sys_clk);
    acq_busy <= 2'h3;
    tick(2);
    rd(3'h3, 3'h0, 16'h0000);
    @(posedge sys_clk);
    avg_mode <= 1'b1;
    tick(2);
    rd(3'h3, 3'h0, 16'h0006);
    @(posedge sys_clk);
    acq_busy <= 2'h0;
    tick(2);
    rd(3'h3, 3'h0, 16'h0000);
    $display("test acquisition done");
    // Probe memory and trigger wait levels from random values
    // Rising probe levels latch events too, so track them for the later read
    prev = 2'h0;
    acc = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge sys_clk);
      probe_mem_busy <= lfsr[1:0];
      trig_wait <= lfsr[3:2];
      acc = acc | {13'h0000, lfsr[1:0] & ~prev, 1'b0};
      prev = lfsr[1:0];
      tick(2);
      rd(3'h4, 3'h0, {13'h0000, lfsr[1:0], 1'b0});
      rd(3'h5, 3'h0, {13'h0000, lfsr[3:2], 1'b0});
    end
    rd(3'h4, 3'h1, acc);
    // Falling edges only, with the rising filter off
    wr(3'h4, 3'h3, 16'h0000);
    wr(3'h4, 3'h4, 16'h0006);
    @(posedge sys_clk);
    probe_mem_busy <= 2'h3;
    tick(2);
    rd(3'h4, 3'h1, 16'h0000);
    @(posedge sys_clk);
    probe_mem_busy <= 2'h0;
    tick(3);
    rd(3'h4, 3'h1, 16'h0006);
    $display("test levels and filters done");
    // Refusals, bit 15 and defaults command
    wr(3'h1, 3'h0, 16'hFFFF);
    wr(3'h7, 3'h2, 16'hFFFF);
    wr(3'h2, 3'h6, 16'hFFFF);
    rd(3'h7, 3'h0, 16'h0000);
    lfsr = lfsr_next(lfsr);
    wr(3'h1, 3'h2, lfsr[15:0] | 16'h8000);
    rd(3'h1, 3'h2, lfsr[15:0] & 16'h7FFF);
    wr(3'h0, 3'h3, 16'h0000);
    @(posedge sys_clk);
    cmd_preset <= 1'b1;
    @(posedge sys_clk);
    cmd_preset <= 1'b0;
    chk_defaults(1'b0);
    $display("test refusals and defaults done");
    tick(3);
    cmp("pending reads", 16'h0000, 16'(exp_q.size()));
    results();
  end
endmodule
